// [hw/frw_ctrl.sv]
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module frw_ctrl
#(
   parameter int unsigned GAP_US = 500,
   parameter int unsigned PARAM_ERASE_US = 4000000,
   parameter int unsigned MAIN_ERASE_US = 5000000,
   parameter int unsigned CHIP_ERASE_US = 700000000
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   output logic irq,
   // flash pins
   output frw_pkg::frw_pins_type flash_o,
   input wire logic [15:0] dq_in
);

   frw_pkg::frw_state_type state_r;
   frw_pkg::frw_cmd_type cmd_r;
   frw_pkg::frw_pins_type pins_r;
   logic [frw_pkg::CNT_W-1:0] cnt_r;
   logic [21:0] cmd_addr_r;
   logic [15:0] cmd_data_r;
   logic [15:0] rdata_r;
   logic go_r;
   logic vpp_req_r;
   logic launched_r;
   logic poll_r;
   logic [frw_pkg::IRQ_W-1:0] irq_stat_r;
   logic [frw_pkg::IRQ_W-1:0] irq_mask_r;
   logic [frw_pkg::IRQ_W-1:0] ev;
   logic ev_done;
   logic ev_timeout;
   logic ev_err;
   logic ev_refused;
   logic [frw_pkg::US_W-1:0] to_cnt_r;
   logic [frw_pkg::US_W-1:0] to_limit;
   logic [15:0] gap_cnt_r;
   logic gap_busy;
   logic gap_load;
   logic poll_start;
   logic tick;
   logic cnt_zero;
   logic ready_seen;
   logic acc_wr;
   logic setup_rd;
   logic addr_hit;

   frw_us_tick u_tick
   (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );

   assign flash_o = pins_r;
   assign cnt_zero = (cnt_r == '0);
   assign gap_busy = (gap_cnt_r != 16'h0000);

   // the polled bit: global when asked, since it tolerates loose read timing
   assign ready_seen = cmd_r.poll_global ? dq_in[frw_pkg::GLOBAL_READY_BIT]
                                         : dq_in[frw_pkg::PARTITION_READY_BIT];

   // poll limit per command class
   always_comb
   begin
      unique case (cmd_r.limit_cls)
         3'd0: to_limit = frw_pkg::US_W'(frw_pkg::T_PSUS_US);
         3'd1: to_limit = frw_pkg::US_W'(frw_pkg::T_ESUS_US);
         3'd2: to_limit = frw_pkg::US_W'(PARAM_ERASE_US);
         3'd3: to_limit = frw_pkg::US_W'(MAIN_ERASE_US);
         default: to_limit = frw_pkg::US_W'(CHIP_ERASE_US);
      endcase
   end

   // sequencer driving the flash pins; starts by holding reset after power-up
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= frw_pkg::ST_RST_LOW;
         cnt_r <= frw_pkg::CNT_W'(frw_pkg::RST_PULSE_CYC - 1);
         pins_r <= '{rst_n: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                     addr: 22'h00_0000, dq_out: 16'h0000, dq_oe: 1'b0,
                     program_supply_en: 1'b0};
         rdata_r <= 16'h0000;
         launched_r <= 1'b0;
         poll_r <= 1'b0;
         ev_done <= 1'b0;
         ev_timeout <= 1'b0;
         ev_err <= 1'b0;
         ev_refused <= 1'b0;
         gap_load <= 1'b0;
         poll_start <= 1'b0;
      end
      else
      begin
         ev_done <= 1'b0;
         ev_timeout <= 1'b0;
         ev_err <= 1'b0;
         ev_refused <= 1'b0;
         gap_load <= 1'b0;
         poll_start <= 1'b0;
         // supply stays up while an operation is unconfirmed
         pins_r.program_supply_en <= vpp_req_r | launched_r;
         if (!cnt_zero)
         begin
            cnt_r <= cnt_r - 1'b1;
         end
         unique case (state_r)
            frw_pkg::ST_IDLE:
            begin
               if (go_r)
               begin
                  unique case (cmd_r.op)
                     frw_pkg::OP_RESET:
                     begin
                        pins_r.rst_n <= 1'b0;
                        // a running operation needs the long abort time
                        if (launched_r)
                        begin
                           cnt_r <= frw_pkg::CNT_W'(frw_pkg::RST_BUSY_CYC - 1);
                        end
                        else
                        begin
                           cnt_r <= frw_pkg::CNT_W'(frw_pkg::RST_PULSE_CYC - 1);
                        end
                        state_r <= frw_pkg::ST_RST_LOW;
                     end
                     frw_pkg::OP_WRITE:
                     begin
                        // a new launch before completion was confirmed is refused
                        if (cmd_r.start && launched_r)
                        begin
                           ev_refused <= 1'b1;
                        end
                        else
                        begin
                           state_r <= frw_pkg::ST_GAP;
                        end
                     end
                     frw_pkg::OP_READ:
                     begin
                        state_r <= frw_pkg::ST_RD_START;
                     end
                     frw_pkg::OP_POLL:
                     begin
                        poll_r <= 1'b1;
                        poll_start <= 1'b1;
                        cnt_r <= frw_pkg::CNT_W'(frw_pkg::READY_FALL_CYC - 1);
                        state_r <= frw_pkg::ST_POLL_DLY;
                     end
                     default:
                     begin
                        ev_done <= 1'b1;
                     end
                  endcase
               end
            end
            frw_pkg::ST_RST_LOW:
            begin
               if (cnt_zero)
               begin
                  pins_r.rst_n <= 1'b1;
                  launched_r <= 1'b0;
                  cnt_r <= frw_pkg::CNT_W'(frw_pkg::RECOV_CYC - 1);
                  state_r <= frw_pkg::ST_RST_REC;
               end
            end
            frw_pkg::ST_RST_REC:
            begin
               if (cnt_zero)
               begin
                  ev_done <= 1'b1;
                  state_r <= frw_pkg::ST_IDLE;
               end
            end
            frw_pkg::ST_GAP:
            begin
               // a suspend waits out the gap after the last resume
               if (!(cmd_r.susp == frw_pkg::SUSP_SUSPEND && gap_busy))
               begin
                  pins_r.addr <= cmd_addr_r;
                  pins_r.dq_out <= cmd_data_r;
                  pins_r.dq_oe <= 1'b1;
                  pins_r.ce_n <= 1'b0;
                  pins_r.we_n <= 1'b0;
                  gap_load <= (cmd_r.susp == frw_pkg::SUSP_RESUME);
                  if (cmd_r.start)
                  begin
                     launched_r <= 1'b1;
                  end
                  cnt_r <= frw_pkg::CNT_W'(frw_pkg::WE_LOW_CYC - 1);
                  state_r <= frw_pkg::ST_WR_LOW;
               end
            end
            frw_pkg::ST_WR_LOW:
            begin
               if (cnt_zero)
               begin
                  pins_r.we_n <= 1'b1;
                  pins_r.ce_n <= 1'b1;
                  cnt_r <= frw_pkg::CNT_W'(frw_pkg::HIGH_CYC - 1);
                  state_r <= frw_pkg::ST_WR_REC;
               end
            end
            frw_pkg::ST_WR_REC:
            begin
               // data held through the high time, then released
               if (cnt_zero)
               begin
                  pins_r.dq_oe <= 1'b0;
                  ev_done <= 1'b1;
                  state_r <= frw_pkg::ST_IDLE;
               end
            end
            frw_pkg::ST_POLL_DLY:
            begin
               if (cnt_zero)
               begin
                  state_r <= frw_pkg::ST_RD_START;
               end
            end
            frw_pkg::ST_RD_START:
            begin
               pins_r.addr <= cmd_addr_r;
               pins_r.ce_n <= 1'b0;
               pins_r.oe_n <= 1'b0;
               cnt_r <= frw_pkg::CNT_W'(frw_pkg::ACC_CYC - 1);
               state_r <= frw_pkg::ST_RD_LOW;
            end
            frw_pkg::ST_RD_LOW:
            begin
               if (cnt_zero)
               begin
                  rdata_r <= dq_in;
                  pins_r.ce_n <= 1'b1;
                  pins_r.oe_n <= 1'b1;
                  if (poll_r && ready_seen)
                  begin
                     // of the poll results, only an error-free one lets the supply drop
                     if ((dq_in & frw_pkg::OPERATION_ERROR_BITS) == 16'h0000)
                     begin
                        launched_r <= 1'b0;
                     end
                     else
                     begin
                        ev_err <= 1'b1;
                     end
                     cnt_r <= frw_pkg::CNT_W'(frw_pkg::RECOV_CYC - 1);
                     state_r <= frw_pkg::ST_READY_REC;
                  end
                  else
                  begin
                     cnt_r <= frw_pkg::CNT_W'(frw_pkg::HIGH_CYC - 1);
                     state_r <= frw_pkg::ST_RD_REC;
                  end
               end
            end
            frw_pkg::ST_RD_REC:
            begin
               if (cnt_zero)
               begin
                  if (poll_r && (to_cnt_r > to_limit))
                  begin
                     poll_r <= 1'b0;
                     ev_timeout <= 1'b1;
                     state_r <= frw_pkg::ST_IDLE;
                  end
                  else if (poll_r)
                  begin
                     state_r <= frw_pkg::ST_RD_START;
                  end
                  else
                  begin
                     ev_done <= 1'b1;
                     state_r <= frw_pkg::ST_IDLE;
                  end
               end
            end
            frw_pkg::ST_READY_REC:
            begin
               // outputs are trusted only after the recovery time
               if (cnt_zero)
               begin
                  poll_r <= 1'b0;
                  ev_done <= 1'b1;
                  state_r <= frw_pkg::ST_IDLE;
               end
            end
            default:
            begin
               state_r <= frw_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // poll limit counter in microseconds
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         to_cnt_r <= '0;
      end
      else if (poll_start)
      begin
         to_cnt_r <= '0;
      end
      else if (poll_r && tick && (to_cnt_r != '1))
      begin
         to_cnt_r <= to_cnt_r + 1'b1;
      end
   end

   // resume-to-suspend gap counter in microseconds
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_cnt_r <= 16'h0000;
      end
      else if (gap_load)
      begin
         gap_cnt_r <= 16'(GAP_US + 1); // one extra, the first tick may follow at once
      end
      else if (tick && gap_busy)
      begin
         gap_cnt_r <= gap_cnt_r - 16'h0001;
      end
   end

   // apb decode: two-cycle transfers, read data captured in setup
   assign pready = 1'b1;
   assign acc_wr = psel && penable && pwrite;
   assign setup_rd = psel && !penable;
   assign addr_hit = (paddr == frw_pkg::OFS_CMD_ADDR) || (paddr == frw_pkg::OFS_CMD_DATA) ||
                     (paddr == frw_pkg::OFS_CMD) || (paddr == frw_pkg::OFS_CFG) ||
                     (paddr == frw_pkg::OFS_STATUS) || (paddr == frw_pkg::OFS_IRQ_STAT) ||
                     (paddr == frw_pkg::OFS_IRQ_MASK);

   // software registers; a command written while busy is dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_addr_r <= 22'h00_0000;
         cmd_data_r <= 16'h0000;
         cmd_r <= '0;
         go_r <= 1'b0;
         vpp_req_r <= 1'b0;
         irq_mask_r <= '0;
      end
      else
      begin
         go_r <= 1'b0;
         if (acc_wr)
         begin
            unique case (paddr)
               frw_pkg::OFS_CMD_ADDR: cmd_addr_r <= pwdata[21:0];
               frw_pkg::OFS_CMD_DATA: cmd_data_r <= pwdata[15:0];
               frw_pkg::OFS_CMD:
               begin
                  if (state_r == frw_pkg::ST_IDLE && !go_r)
                  begin
                     cmd_r <= frw_pkg::frw_cmd_type'(pwdata[9:0]);
                     go_r <= 1'b1;
                  end
               end
               frw_pkg::OFS_CFG: vpp_req_r <= pwdata[0];
               frw_pkg::OFS_IRQ_MASK: irq_mask_r <= pwdata[frw_pkg::IRQ_W-1:0];
               default:
               begin
               end
            endcase
         end
      end
   end

   // read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= frw_pkg::RST_WORD;
         pslverr <= 1'b0;
      end
      else if (setup_rd)
      begin
         pslverr <= !addr_hit;
         prdata <= frw_pkg::RST_WORD;
         unique case (paddr)
            frw_pkg::OFS_CMD_ADDR: prdata <= {10'h000, cmd_addr_r};
            frw_pkg::OFS_CMD_DATA: prdata <= {16'h0000, cmd_data_r};
            frw_pkg::OFS_CMD: prdata <= {22'h00_0000, cmd_r};
            frw_pkg::OFS_CFG: prdata <= {31'h0000_0000, vpp_req_r};
            frw_pkg::OFS_STATUS: prdata <= {rdata_r, 12'h000, gap_busy, launched_r,
                                            pins_r.program_supply_en,
                                            (state_r != frw_pkg::ST_IDLE) || go_r};
            frw_pkg::OFS_IRQ_STAT: prdata <= {28'h000_0000, irq_stat_r};
            frw_pkg::OFS_IRQ_MASK: prdata <= {28'h000_0000, irq_mask_r};
            default:
            begin
            end
         endcase
      end
   end

   // sticky events; a new event wins over a same-cycle clear
   assign ev = {ev_refused, ev_err, ev_timeout, ev_done};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_r <= '0;
      end
      else if (acc_wr && paddr == frw_pkg::OFS_IRQ_STAT)
      begin
         irq_stat_r <= (irq_stat_r & ~pwdata[frw_pkg::IRQ_W-1:0]) | ev;
      end
      else
      begin
         irq_stat_r <= irq_stat_r | ev;
      end
   end

   assign irq = |(irq_stat_r & irq_mask_r);

endmodule
`default_nettype wire

// [hw/frw_pkg.sv]
// Functional notes
// - hold reset low at least 100 ns
// - sample outputs only after recovery time
// - power-up reset held low 100 ns minimum
// - keep program supply until errors read zero; a reset op drops it unless cfg holds it up
// - resume to next suspend at least 500 us
// - partition ready does not mean sequencer free; a poll on the partition bit still clears the launch and lets the supply drop
// - poll global bit when timing is tight
package frw_pkg;

   // clock
   localparam int CLK_NS = 20;
   localparam int US_NS = 1000;
   localparam int US_CYC = US_NS / CLK_NS;

   // pin timing, least times rounded up to whole cycles
   localparam int T_RST_PULSE_NS = 100;
   localparam int RST_PULSE_CYC = (T_RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_RST_BUSY_US = 22;
   localparam int RST_BUSY_CYC = (T_RST_BUSY_US * US_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_RECOV_NS = 150;
   localparam int RECOV_CYC = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_WE_LOW_NS = 50;
   localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_HIGH_NS = 30;
   localparam int HIGH_CYC = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_ACC_NS = 80;
   localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_READY_FALL_NS = T_ACC_NS + 100;
   localparam int READY_FALL_CYC = (T_READY_FALL_NS + CLK_NS - 1) / CLK_NS;

   // suspend latencies in microseconds, used as poll limits
   localparam int T_PSUS_US = 10;
   localparam int T_ESUS_US = 20;

   // counter widths
   localparam int CNT_W = 11;
   localparam int US_W = 32;

   // status bits of the device
   localparam int GLOBAL_READY_BIT = 15;
   localparam int PARTITION_READY_BIT = 7;
   localparam logic [15:0] OPERATION_ERROR_BITS = 16'h003a;

   // register offsets
   localparam logic [7:0] OFS_CMD_ADDR = 8'h00;
   localparam logic [7:0] OFS_CMD_DATA = 8'h04;
   localparam logic [7:0] OFS_CMD = 8'h08;
   localparam logic [7:0] OFS_CFG = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

   // interrupt status bit positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_TIMEOUT = 1;
   localparam int IRQ_OP_ERR = 2;
   localparam int IRQ_REFUSED = 3;
   localparam int IRQ_W = 4;

   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_RESET,
      OP_WRITE,
      OP_READ,
      OP_POLL
   } frw_op_type;

   typedef enum logic [1:0] {
      SUSP_NONE,
      SUSP_RESUME,
      SUSP_SUSPEND
   } frw_susp_type;

   // command word: start launches an erase or program
   typedef struct packed {
      logic start;
      frw_susp_type susp;
      logic [2:0] limit_cls;
      logic poll_global;
      frw_op_type op;
   } frw_cmd_type;

   // pins toward the flash
   typedef struct packed {
      logic rst_n;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [21:0] addr;
      logic [15:0] dq_out;
      logic dq_oe;
      logic program_supply_en;
   } frw_pins_type;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_RST_LOW,
      ST_RST_REC,
      ST_GAP,
      ST_WR_LOW,
      ST_WR_REC,
      ST_RD_START,
      ST_RD_LOW,
      ST_RD_REC,
      ST_POLL_DLY,
      ST_READY_REC
   } frw_state_type;

endpackage

// [hw/frw_us_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module frw_us_tick
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // one-cycle pulse every microsecond
   output logic tick
);

   logic [7:0] div_r;

   // free-running divider, pulse on wrap
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_r <= 8'h00;
         tick <= 1'b0;
      end
      else if (div_r == 8'(frw_pkg::US_CYC - 1))
      begin
         div_r <= 8'h00;
         tick <= 1'b1;
      end
      else
      begin
         div_r <= div_r + 8'h01;
         tick <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// [verification/frw_ctrl_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module frw_ctrl_properties
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // flash pins
   input wire frw_pkg::frw_pins_type flash_o
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a short reset pulse may leave the device half reset
   property p_rst_width;
      $fell(flash_o.rst_n) |-> !flash_o.rst_n [*5];
   endproperty
   a_rst_width: assert property (p_rst_width) else $error("device reset pulse too short");
   // no strobe before the device has recovered from reset
   property p_recovery;
      $rose(flash_o.rst_n) |-> (flash_o.oe_n && flash_o.we_n) [*8];
   endproperty
   a_recovery: assert property (p_recovery) else $error("strobe during reset recovery");
   // write strobe is exactly three cycles low
   property p_we_width;
      $fell(flash_o.we_n) |-> !flash_o.we_n [*3] ##1 flash_o.we_n;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
   property p_we_high;
      $rose(flash_o.we_n) |-> flash_o.we_n [*2];
   endproperty
   a_we_high: assert property (p_we_high) else $error("write strobe high time short");
   property p_wr_qual;
      !flash_o.we_n |-> flash_o.dq_oe && !flash_o.ce_n && flash_o.oe_n;
   endproperty
   a_wr_qual: assert property (p_wr_qual) else $error("write without data or select");
   // driving the data pins while the device drives them is a fight
   property p_no_fight;
      !flash_o.oe_n |-> !flash_o.dq_oe && !flash_o.ce_n;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("data pins driven during read");
   property p_rd_width;
      $fell(flash_o.oe_n) |-> !flash_o.oe_n [*4] ##1 flash_o.oe_n;
   endproperty
   a_rd_width: assert property (p_rd_width) else $error("read strobe width wrong");
   property p_pready;
      psel && penable |-> pready;
   endproperty
   a_pready: assert property (p_pready) else $error("apb access not answered");
   property p_unmapped;
      psel && !penable && !pwrite && paddr > 8'h18 |=> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   c_write: cover property ($fell(flash_o.we_n));
   c_read: cover property ($fell(flash_o.oe_n));
   c_reset: cover property ($rose(flash_o.rst_n));
endmodule
bind frw_ctrl frw_ctrl_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .flash_o(flash_o));
`default_nettype wire

// [verification/frw_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module frw_flash_model
#(
   parameter int OP_CYC = 1000,
   parameter int SUS_CYC = 100
)
(
   // bench clock
   input wire logic pclk,
   // pins from the controller, error injection from the bench
   input wire frw_pkg::frw_pins_type pins,
   input wire logic inject_err,
   // data pins back to the controller
   output logic [15:0] dq_in
);
   int busy_cnt = 0;
   logic we_q = 1'b1;
   logic rdy;
   assign rdy = (busy_cnt == 0);
   // one sequencer and one partition, so both ready bits follow it
   always @(posedge pclk)
   begin
      we_q <= pins.we_n;
      if (!pins.rst_n)
         busy_cnt <= 0; // aborts at once, inside both reset limits
      else if (pins.we_n && !we_q && pins.dq_out[7:0] == 8'hd0)
         busy_cnt <= OP_CYC; // erase or program, far inside its limit
      else if (pins.we_n && !we_q && pins.dq_out[7:0] == 8'hb0 && busy_cnt > SUS_CYC)
         busy_cnt <= SUS_CYC; // suspend latency bound
      else if (busy_cnt > 0)
         busy_cnt <= busy_cnt - 1;
   end
   // released pins float, so they scramble rather than keep the old value
   always @(posedge pclk)
   begin
      if (pins.rst_n && !pins.ce_n && !pins.oe_n)
         dq_in <= {rdy, 7'h00, rdy, 1'b0, {2{inject_err}}, 4'h0};
      else
         dq_in <= ~dq_in;
   end
   initial dq_in = 16'h0000;
endmodule
`default_nettype wire

// [verification/frw_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module frw_ctrl_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic inject_err = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, irq;
   frw_pkg::frw_pins_type flash_o;
   logic [15:0] dq_in;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   time we_t = 0;
   time we_gap = 0;
   time rst_t = 0;
   time rst_len = 0;
   always #10 pclk = ~pclk;
   frw_ctrl #(.GAP_US(5), .PARAM_ERASE_US(60), .MAIN_ERASE_US(60), .CHIP_ERASE_US(80)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .flash_o(flash_o), .dq_in(dq_in));
   frw_flash_model u_flash (.pclk(pclk), .pins(flash_o),
      .inject_err(inject_err), .dq_in(dq_in));
   // pin timing seen by the bench
   always @(negedge flash_o.we_n)
   begin
      we_gap = $time - we_t;
      we_t = $time;
   end
   always @(negedge flash_o.rst_n) rst_t = $time;
   always @(posedge flash_o.rst_n) rst_len = $time - rst_t;
   // a hung wait ends the run as a failure
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         fails++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one apb transfer; read data taken at the edge where pready is seen
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (3) @(posedge pclk);
      do
      begin
         apb(1'b0, frw_pkg::OFS_STATUS, 32'h0000_0000);
         n++;
      end
      while (rd[0] !== 1'b0 && n < 3000);
      check("busy", 32'h0000_0000, {31'h0, rd[0]});
   endtask
   function automatic logic [31:0] cmdw(logic [2:0] op, logic g, logic [2:0] lim,
      logic [1:0] su, logic st);
      return {22'h0, st, su, lim, g, op};
   endfunction
   task automatic cmd(input logic [2:0] op, input logic g, input logic [2:0] lim,
      input logic [1:0] su, input logic st);
      apb(1'b1, frw_pkg::OFS_CMD, cmdw(op, g, lim, su, st));
      wait_idle();
   endtask
   task automatic flash_wr(input logic [15:0] d, input logic [1:0] su, input logic st);
      apb(1'b1, frw_pkg::OFS_CMD_DATA, {16'h0000, d});
      cmd(3'd2, 1'b0, 3'd0, su, st);
   endtask
   task automatic reg_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(name, exp, rd);
   endtask
   // reset sequence, reset values, unmapped place, field widths
   task automatic t_reset();
      wait_idle();
      reg_chk("irq_stat", frw_pkg::OFS_IRQ_STAT, 32'h0000_0001);
      reg_chk("irq_mask", frw_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      reg_chk("cfg", frw_pkg::OFS_CFG, 32'h0000_0000);
      reg_chk("unmapped", 8'h1c, 32'h0000_0000);
      check("pslverr", 32'h0000_0001, {31'h0, pslverr});
      apb(1'b1, frw_pkg::OFS_CMD_ADDR, 32'hffff_ffff);
      reg_chk("cmd_addr", frw_pkg::OFS_CMD_ADDR, 32'h003f_ffff);
      apb(1'b1, frw_pkg::OFS_CMD_ADDR, 32'h0000_0000);
   endtask
   // status read of an idle device, interrupt raise, mask and clear
   task automatic t_irq();
      apb(1'b1, frw_pkg::OFS_IRQ_STAT, 32'h0000_000f);
      apb(1'b1, frw_pkg::OFS_IRQ_MASK, 32'h0000_0001);
      check("irq", 32'h0000_0000, {31'h0, irq});
      cmd(3'd3, 1'b0, 3'd0, 2'd0, 1'b0);
      reg_chk("status", frw_pkg::OFS_STATUS, 32'h8080_0000);
      check("irq", 32'h0000_0001, {31'h0, irq});
      apb(1'b1, frw_pkg::OFS_IRQ_STAT, 32'h0000_0001);
      check("irq", 32'h0000_0000, {31'h0, irq});
   endtask
   // launch, refused second launch, global poll releases the supply
   task automatic t_launch();
      apb(1'b1, frw_pkg::OFS_IRQ_STAT, 32'h0000_000f);
      flash_wr(16'h00d0, 2'd0, 1'b1);
      reg_chk("status", frw_pkg::OFS_STATUS, 32'h8080_0006);
      flash_wr(16'h00d0, 2'd0, 1'b1);
      reg_chk("irq_stat", frw_pkg::OFS_IRQ_STAT, 32'h0000_0009);
      cmd(3'd4, 1'b1, 3'd2, 2'd0, 1'b0);
      reg_chk("status", frw_pkg::OFS_STATUS, 32'h8080_0000);
   endtask
   // error bits keep the supply up; a reset op with the launch unconfirmed holds 22 us
   task automatic t_error();
      apb(1'b1, frw_pkg::OFS_IRQ_STAT, 32'h0000_000f);
      inject_err <= 1'b1;
      flash_wr(16'h00d0, 2'd0, 1'b1);
      cmd(3'd4, 1'b0, 3'd2, 2'd0, 1'b0);
      apb(1'b0, frw_pkg::OFS_IRQ_STAT, 32'h0000_0000);
      check("irq_err", 32'h0000_0004, rd & 32'h0000_0006);
      reg_chk("status", frw_pkg::OFS_STATUS, 32'h80b0_0006);
      cmd(3'd1, 1'b0, 3'd0, 2'd0, 1'b0);
      check("rst_long", 32'h0000_0001, {31'h0, rst_len >= 22000});
      reg_chk("status", frw_pkg::OFS_STATUS, 32'h80b0_0000);
      inject_err <= 1'b0;
   endtask
   // poll timeout, resume then suspend spaced by the gap, suspend poll succeeds
   task automatic t_gap();
      apb(1'b1, frw_pkg::OFS_IRQ_STAT, 32'h0000_000f);
      flash_wr(16'h00d0, 2'd0, 1'b1);
      cmd(3'd4, 1'b0, 3'd0, 2'd0, 1'b0);
      reg_chk("irq_stat", frw_pkg::OFS_IRQ_STAT, 32'h0000_0003);
      apb(1'b1, frw_pkg::OFS_IRQ_STAT, 32'h0000_000f);
      flash_wr(16'h00d0, 2'd1, 1'b0);
      flash_wr(16'h00b0, 2'd2, 1'b0);
      check("gap", 32'h0000_0001, {31'h0, we_gap >= 5000});
      cmd(3'd4, 1'b0, 3'd1, 2'd0, 1'b0);
      reg_chk("irq_stat", frw_pkg::OFS_IRQ_STAT, 32'h0000_0001);
      reg_chk("status", frw_pkg::OFS_STATUS, 32'h8080_0000);
   endtask
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_irq();
      t_launch();
      t_error();
      t_gap();
      wrap_up();
   end
endmodule
`default_nettype wire
